//--- verilog/cips_pkg.sv
package cips_pkg;

    localparam int unsigned CLK_PERIOD_PS       = 4000;
    localparam int unsigned FAST_PARK_TIME_NS   = 32000;
    localparam int unsigned NORMAL_PARK_TIME_US = 20000;

    // fast park must be complete inside the 32 us window; half of it is used for margin
    localparam int unsigned FAST_PARK_CYCLES    = (FAST_PARK_TIME_NS * 1000 / CLK_PERIOD_PS) / 2;
    // parked shows two edges after the request is seen, so those edges come off the count
    localparam int unsigned PARK_FLAG_LATENCY   = 2;
    // longest time, rounded down
    localparam int unsigned NORMAL_PARK_CYCLES  = (NORMAL_PARK_TIME_US / 1000) * (1000000000 / CLK_PERIOD_PS)
                                                - PARK_FLAG_LATENCY;

    localparam int unsigned GPIO_WIDTH          = 20;
    localparam int unsigned CNT_WIDTH           = 24;

    typedef enum logic [2:0] {
        CIPS_PLL_WAIT,
        CIPS_CFG_LOAD,
        CIPS_RUN,
        CIPS_NORMAL_PARK,
        CIPS_FAST_PARK,
        CIPS_PARKED
    } cips_state_e;

endpackage

//--- verilog/cips_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module cips_sequencer
    import cips_pkg::*;
#(
    parameter int unsigned FAST_PARK_LEN   = FAST_PARK_CYCLES,
    parameter int unsigned NORMAL_PARK_LEN = NORMAL_PARK_CYCLES
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    // power monitor and host requests
    input  wire logic                  early_park_request_n,
    input  wire logic                  projector_power_request,
    // internal pll and flash loader handshakes
    input  wire logic                  pll_locked,
    output logic                       cfg_load_start,
    input  wire logic                  cfg_load_done,
    // mirror park engine
    output logic                       mirror_park_fast,
    output logic                       mirror_park_normal,
    output logic                       mirror_parked,
    // initialization status pin, separate value and enable, driven high and low once out of reset
    output logic                       init_status_out,
    output logic                       init_status_oe,
    // pin enables for flash serial port and gpio
    output logic                       flash_pins_oe,
    output logic [GPIO_WIDTH-1:0]      gpio_oe,
    // outputs forced low in reset
    output logic                       light_source_select_a,
    output logic                       light_source_select_b,
    output logic                       mirror_drive_enable_reset_n
);

    cips_state_e            state_reg;
    logic [CNT_WIDTH-1:0]   park_cnt_reg;
    logic                   load_armed_reg;
    logic                   load_issued_reg;

    // ---------------------------------------------------------------
    // initialization and park sequence
    // ---------------------------------------------------------------
    // the power request is only looked at in run, so a drop during init is ignored
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= CIPS_PLL_WAIT;
        end else begin
            unique case (state_reg)
                CIPS_PLL_WAIT: begin
                    if (!early_park_request_n) begin
                        state_reg <= CIPS_FAST_PARK;
                    end else if (pll_locked) begin
                        state_reg <= CIPS_CFG_LOAD;
                    end
                end
                CIPS_CFG_LOAD: begin
                    if (!early_park_request_n) begin
                        state_reg <= CIPS_FAST_PARK;
                    end else if (cfg_load_done) begin
                        state_reg <= CIPS_RUN;
                    end
                end
                CIPS_RUN: begin
                    if (!early_park_request_n) begin
                        state_reg <= CIPS_FAST_PARK;
                    end else if (!projector_power_request) begin
                        state_reg <= CIPS_NORMAL_PARK;
                    end
                end
                CIPS_NORMAL_PARK: begin
                    // fast park overrides when power loss is imminent
                    if (!early_park_request_n) begin
                        state_reg <= CIPS_FAST_PARK;
                    end else if (park_cnt_reg == CNT_WIDTH'(NORMAL_PARK_LEN - 1)) begin
                        state_reg <= CIPS_PARKED;
                    end
                end
                CIPS_FAST_PARK: begin
                    if (park_cnt_reg == CNT_WIDTH'(FAST_PARK_LEN - 1)) begin
                        state_reg <= CIPS_PARKED;
                    end
                end
                CIPS_PARKED: begin
                    state_reg <= CIPS_PARKED;
                end
            endcase
        end
    end

    // park duration counter, cleared when a park phase starts
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            park_cnt_reg <= '0;
        end else if ((state_reg == CIPS_NORMAL_PARK || state_reg == CIPS_FAST_PARK)
                     && !(state_reg == CIPS_NORMAL_PARK && !early_park_request_n)) begin
            park_cnt_reg <= park_cnt_reg + CNT_WIDTH'(1);
        end else begin
            park_cnt_reg <= '0;
        end
    end

    // ---------------------------------------------------------------
    // flash configuration load request
    // ---------------------------------------------------------------
    // the request is a single pulse; the issued flag keeps a slow flash
    // from being asked again while its loader is still busy
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_armed_reg <= 1'b0;
        end else begin
            load_armed_reg <= (state_reg == CIPS_CFG_LOAD) && !load_armed_reg && !load_issued_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_issued_reg <= 1'b0;
        end else begin
            load_issued_reg <= (state_reg == CIPS_CFG_LOAD) && (load_issued_reg || load_armed_reg);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_load_start <= 1'b0;
        end else begin
            cfg_load_start <= load_armed_reg;
        end
    end

    // ---------------------------------------------------------------
    // initialization status pin
    // ---------------------------------------------------------------
    // the enable drops with reset so the board pullup shows busy until
    // the first edge after release, when the block drives busy itself
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_status_oe <= 1'b0;
        end else begin
            init_status_oe <= 1'b1;
        end
    end

    // states only move forward, so once low the status stays low until reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_status_out <= 1'b0;
        end else begin
            init_status_out <= (state_reg == CIPS_PLL_WAIT)
                            || (state_reg == CIPS_CFG_LOAD);
        end
    end

    // ---------------------------------------------------------------
    // flash serial port and general purpose pin enables
    // ---------------------------------------------------------------
    // clock, data out and both selects share one enable; the selects
    // rely on board pullups while it is low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_pins_oe <= 1'b0;
        end else begin
            flash_pins_oe <= 1'b1;
        end
    end

    // one enable flop per pin keeps each one a plain register output
    for (genvar pin = 0; pin < GPIO_WIDTH; pin++) begin : g_gpio_oe
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                gpio_oe[pin] <= 1'b0;
            end else begin
                gpio_oe[pin] <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // light source selects and mirror drive enable
    // ---------------------------------------------------------------
    // this block has no light source control, so both selects stay low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            light_source_select_a <= 1'b0;
            light_source_select_b <= 1'b0;
        end else begin
            light_source_select_a <= 1'b0;
            light_source_select_b <= 1'b0;
        end
    end

    // the mirror array is enabled in run only; in a park the mirrors
    // belong to the park engine
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mirror_drive_enable_reset_n <= 1'b0;
        end else begin
            mirror_drive_enable_reset_n <= (state_reg == CIPS_RUN);
        end
    end

    // ---------------------------------------------------------------
    // mirror park engine requests
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mirror_park_fast <= 1'b0;
        end else begin
            mirror_park_fast <= (state_reg == CIPS_FAST_PARK);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mirror_park_normal <= 1'b0;
        end else begin
            mirror_park_normal <= (state_reg == CIPS_NORMAL_PARK);
        end
    end

    // parked is held until reset so the monitor may cut power any time after
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mirror_parked <= 1'b0;
        end else begin
            mirror_parked <= (state_reg == CIPS_PARKED);
        end
    end

endmodule

`default_nettype wire

//--- test/cips_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cips_chk
    import cips_pkg::*;
#(
    parameter int unsigned FAST_PARK_LEN   = FAST_PARK_CYCLES,
    parameter int unsigned NORMAL_PARK_LEN = NORMAL_PARK_CYCLES
) (
    input wire logic sys_clk, arst_n, early_park_request_n, projector_power_request, pll_locked,
    input wire logic cfg_load_start, cfg_load_done, init_status_out, init_status_oe, flash_pins_oe,
    input wire logic light_source_select_a, light_source_select_b, mirror_drive_enable_reset_n,
    input wire logic mirror_park_fast, mirror_park_normal, mirror_parked,
    input wire logic [GPIO_WIDTH-1:0] gpio_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // the normal park length runs to millions of cycles, so park lengths are counted here
    logic [31:0] norm_cnt_reg;
    logic [31:0] fast_cnt_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            norm_cnt_reg <= 32'h0;
        end else if (mirror_park_normal) begin
            norm_cnt_reg <= norm_cnt_reg + 32'h1;
        end else begin
            norm_cnt_reg <= 32'h0;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fast_cnt_reg <= 32'h0;
        end else if (mirror_park_fast) begin
            fast_cnt_reg <= fast_cnt_reg + 32'h1;
        end else begin
            fast_cnt_reg <= 32'h0;
        end
    end
    sequence done_s; cfg_load_done && init_status_out; endsequence
    sequence norm_s; mirror_drive_enable_reset_n && !projector_power_request && early_park_request_n; endsequence
    rst_float_a: assert property (disable iff (1'b0) !arst_n |->
        !init_status_oe && !flash_pins_oe && gpio_oe == '0) else $error("pins driven in reset");
    rst_low_a: assert property (disable iff (1'b0) !arst_n |->
        !light_source_select_a && !light_source_select_b && !mirror_drive_enable_reset_n) else $error("not low");
    init_busy_a: assert property ($rose(arst_n) |=> init_status_oe && init_status_out)
        else $error("status not busy");
    load_order_a: assert property (cfg_load_start |-> $past(pll_locked, 2)) else $error("load before lock");
    init_done_a: assert property (done_s |-> ##[1:3] !init_status_out) else $error("status not done");
    done_hold_a: assert property (init_status_oe && !init_status_out |=> !init_status_out)
        else $error("done lost");
    fast_park_a: assert property ($fell(early_park_request_n) && !mirror_parked |-> ##[1:3] mirror_park_fast)
        else $error("no fast park");
    normal_park_a: assert property (norm_s |-> ##[1:3] mirror_park_normal)
        else $error("normal park not started");
    norm_len_a: assert property (norm_cnt_reg <= NORMAL_PARK_LEN) else $error("normal park too long");
    fast_len_a: assert property (fast_cnt_reg <= FAST_PARK_LEN) else $error("fast park too long");
    park_end_a: assert property ($fell(mirror_park_normal) |-> mirror_parked || mirror_park_fast)
        else $error("normal park not ended");
    fast_end_a: assert property ($fell(mirror_park_fast) |-> mirror_parked)
        else $error("fast park not ended");
endmodule
bind cips_sequencer cips_chk #(
    .FAST_PARK_LEN               (FAST_PARK_LEN),
    .NORMAL_PARK_LEN             (NORMAL_PARK_LEN)
) u_cips_chk (
    .sys_clk                     (sys_clk),
    .arst_n                      (arst_n),
    .early_park_request_n        (early_park_request_n),
    .projector_power_request     (projector_power_request),
    .pll_locked                  (pll_locked),
    .cfg_load_start              (cfg_load_start),
    .cfg_load_done               (cfg_load_done),
    .init_status_out             (init_status_out),
    .init_status_oe              (init_status_oe),
    .flash_pins_oe               (flash_pins_oe),
    .light_source_select_a       (light_source_select_a),
    .light_source_select_b       (light_source_select_b),
    .mirror_drive_enable_reset_n (mirror_drive_enable_reset_n),
    .mirror_park_fast            (mirror_park_fast),
    .mirror_park_normal          (mirror_park_normal),
    .mirror_parked               (mirror_parked),
    .gpio_oe                     (gpio_oe)
);
`default_nettype wire

//--- test/cips_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cips_partner (
    input wire logic sys_clk, arst_n, cfg_load_start, slow,
    output var logic pll_locked, cfg_load_done
);
    // history of load starts; a slow flash answers much later
    logic [23:0] sh_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_reg <= 24'h0;
            pll_locked <= 1'b0;
        end else begin
            sh_reg <= {sh_reg[22:0], cfg_load_start};
            pll_locked <= 1'b1;
        end
    end
    assign cfg_load_done = slow ? sh_reg[23] : sh_reg[1];
endmodule
`default_nettype wire

//--- test/controller_init_and_park_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s %0h %0h", n, e, a); end end
module controller_init_and_park_sequencer_test;
    import cips_pkg::*;
    // reset starts unknown so the first drive low in boot is a real reset edge
    logic sys_clk = 1'b0, arst_n, park_n = 1'b1, proj = 1'b1, slow = 1'b0;
    logic lock, ld_go, ld_done, fast, norm, parked, st_out, st_oe, fl_oe, lsa, lsb, mde_n;
    logic [GPIO_WIDTH-1:0] gpio_oe;
    int fails = 0, n_tests = 0, c;
    cips_sequencer #(.FAST_PARK_LEN(8), .NORMAL_PARK_LEN(40)) u_cips_sequencer (.sys_clk(sys_clk),
        .arst_n(arst_n), .early_park_request_n(park_n), .projector_power_request(proj), .pll_locked(lock),
        .cfg_load_start(ld_go), .cfg_load_done(ld_done), .mirror_park_fast(fast), .mirror_park_normal(norm),
        .mirror_parked(parked), .init_status_out(st_out), .init_status_oe(st_oe), .flash_pins_oe(fl_oe),
        .gpio_oe(gpio_oe), .light_source_select_a(lsa), .light_source_select_b(lsb),
        .mirror_drive_enable_reset_n(mde_n));
    cips_partner u_cips_partner (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_load_start(ld_go),
        .slow(slow), .pll_locked(lock), .cfg_load_done(ld_done));
    initial forever #2 sys_clk = ~sys_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic boot(input logic s);
        arst_n = 1'b0;
        park_n = 1'b1;
        proj = 1'b1;
        slow = s;
        cyc(20);
        `CHK("float", 3'b000, {st_oe, fl_oe, |gpio_oe})
        `CHK("low", 3'b000, {lsa, lsb, mde_n})
        arst_n = 1'b1;
        cyc(1);
        `CHK("busy", 4'hf, {st_oe, st_out, fl_oe, &gpio_oe})
        for (c = 0; c < 60 && st_out !== 1'b0; c++) cyc(1);
        `CHK("done", 3'b101, {st_oe, st_out, mde_n})
        `CHK("order", s, c > 20)
    endtask
    task automatic park(input logic f, input int lo, input int hi);
        // requests are levels, so the host keeps them asserted until parked
        if (f) park_n = 1'b0;
        else proj = 1'b0;
        for (c = 0; c < 100 && parked !== 1'b1; c++) begin
            cyc(1);
            if (c == 4) `CHK("mode", {f, !f}, {fast, norm})
        end
        `CHK("time", 1'b1, c >= lo && c <= hi)
        `CHK("hold", 3'b100, {st_oe, st_out, mde_n})
    endtask
    initial begin
        boot(1'b1);
        park(1'b0, 40, 46);
        boot(1'b0);
        park(1'b1, 8, 14);
        park_n = 1'b1;
        proj = 1'b0;
        cyc(5);
        `CHK("stay", 3'b100, {parked, fast, norm})
        end_of_test();
    end
    initial begin
        cyc(2000);
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
